// file: include/rcch_consts.vh
// Constants for the ranging configuration command handler.
`ifndef RCCH_CONSTS_VH
`define RCCH_CONSTS_VH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define RCCH_HEAD_BYTE 8'h5a
`define RCCH_REPLY_LEN 8'h05
`define RCCH_LEN_NOPARAM 8'h04
`define RCCH_LEN_THRESH 8'h06
`define RCCH_LEN_WORD 8'h08

// ----------------------------------------
// Instruction codes
// ----------------------------------------
`define RCCH_CMD_SAVE 8'h11
`define RCCH_CMD_THRESH 8'h4f
`define RCCH_CMD_TX_IDENT 8'h50
`define RCCH_CMD_RX_IDENT 8'h51
`define RCCH_CMD_CAN_RATE 8'h52

// ----------------------------------------
// Values and status
// ----------------------------------------
`define RCCH_THRESH_FORBID 16'hffff
`define RCCH_RATE_1M 32'h000f4240
`define RCCH_RATE_500K 32'h0007a120
`define RCCH_RATE_250K 32'h0003d090
`define RCCH_RATE_125K 32'h0001e848
`define RCCH_STATUS_OK 8'h00
`define RCCH_STATUS_FAIL 8'hff

// ----------------------------------------
// Reset values of the live settings
// ----------------------------------------
`define RCCH_RST_THRESH 16'h0000
`define RCCH_RST_TX_IDENT 32'h00000003
`define RCCH_RST_RX_IDENT 32'h00000003
`define RCCH_RST_CAN_RATE 32'h000f4240

`endif

// file: logic/rcch_reply_tx.v
// Reply frame serialiser: head, length, code, status, checksum.
`timescale 1ns/1ps

module rcch_reply_tx (
    // Clock and reset
    input wire clk_sys,
    input wire arst_n,
    // Request from the interpreter
    input wire start,
    input wire [7:0] code,
    input wire [7:0] status,
    // Byte stream out
    output reg tx_valid_q,
    output reg [7:0] tx_byte_q,
    input wire tx_ready,
    output reg busy_q
);
`include "rcch_consts.vh"

    reg [2:0] idx_q;
    reg [7:0] sum_q;
    reg [7:0] code_q;
    reg [7:0] status_q;
    reg [7:0] nxt;

    always @*
    begin
        case (idx_q)
            3'h0: nxt = `RCCH_HEAD_BYTE;
            3'h1: nxt = `RCCH_REPLY_LEN;
            3'h2: nxt = code_q;
            3'h3: nxt = status_q;
            default: nxt = sum_q;
        endcase
    end

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            idx_q <= 3'h0;
            sum_q <= 8'h00;
            code_q <= 8'h00;
            status_q <= 8'h00;
            tx_valid_q <= 1'b0;
            tx_byte_q <= 8'h00;
            busy_q <= 1'b0;
        end
        else if (!busy_q)
        begin
            if (start)
            begin
                busy_q <= 1'b1;
                code_q <= code;
                status_q <= status;
                idx_q <= 3'h0;
                sum_q <= 8'h00;
            end
        end
        else if (!tx_valid_q || tx_ready)
        begin
            if (tx_valid_q && idx_q == 3'h5)
            begin
                tx_valid_q <= 1'b0;
                busy_q <= 1'b0;
            end
            else if (idx_q != 3'h5)
            begin
                // Checksum is the low byte of the sum of all earlier bytes.
                tx_valid_q <= 1'b1;
                tx_byte_q <= nxt;
                sum_q <= sum_q + nxt;
                idx_q <= idx_q + 3'h1;
            end
            else
            begin
                tx_valid_q <= 1'b0;
                busy_q <= 1'b0;
            end
        end
    end

endmodule

// file: logic/rcch_top.v
// Serial configuration instruction handler: parser, settings and replies.
`timescale 1ns/1ps

module rcch_top (
    // Clock and reset
    input wire clk_sys,
    input wire arst_n,
    // Received serial bytes, one-cycle strobe from the UART receiver
    input wire rx_valid,
    input wire [7:0] rx_byte,
    // Reply bytes to the UART transmitter
    output wire tx_valid,
    output wire [7:0] tx_byte,
    input wire tx_ready,
    // Non-volatile store handshake
    output reg nv_write_q,
    output reg [31:0] nv_tx_ident_q,
    output reg [31:0] nv_rx_ident_q,
    output reg [31:0] nv_can_rate_q,
    output reg [15:0] nv_thresh_q,
    input wire nv_done,
    input wire nv_fail,
    // Values loaded from storage at power-up
    input wire [15:0] boot_thresh,
    input wire [31:0] boot_tx_ident,
    input wire [31:0] boot_rx_ident,
    input wire [31:0] boot_can_rate,
    // Live settings
    output reg [15:0] thresh_q,
    output reg thresh_en_q,
    output reg [31:0] can_tx_ident_q,
    output reg [31:0] can_rx_ident_q,
    output reg [31:0] can_rate_q,
    // Status
    output reg busy_q
);
`include "rcch_consts.vh"

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function rate_ok;
        input [31:0] r;
        begin
            rate_ok = (r == `RCCH_RATE_1M) || (r == `RCCH_RATE_500K) ||
                (r == `RCCH_RATE_250K) || (r == `RCCH_RATE_125K);
        end
    endfunction

    function [7:0] len_for;
        input [7:0] c;
        begin
            case (c)
                `RCCH_CMD_SAVE: len_for = `RCCH_LEN_NOPARAM;
                `RCCH_CMD_THRESH: len_for = `RCCH_LEN_THRESH;
                `RCCH_CMD_TX_IDENT: len_for = `RCCH_LEN_WORD;
                `RCCH_CMD_RX_IDENT: len_for = `RCCH_LEN_WORD;
                `RCCH_CMD_CAN_RATE: len_for = `RCCH_LEN_WORD;
                default: len_for = 8'h00;
            endcase
        end
    endfunction

    // ----------------------------------------
    // Parser state
    // ----------------------------------------
    localparam [4:0] ST_HEAD = 5'h01;
    localparam [4:0] ST_LEN = 5'h02;
    localparam [4:0] ST_BODY = 5'h04;
    localparam [4:0] ST_EXEC = 5'h08;
    localparam [4:0] ST_SAVE = 5'h10;

    reg [4:0] st_q;
    reg [7:0] len_q;
    reg [7:0] cnt_q;
    reg [7:0] sum_q;
    reg [7:0] cmd_q;
    reg [31:0] par_q;
    reg boot_q;
    reg rep_start_q;
    reg [7:0] rep_code_q;
    reg [7:0] rep_status_q;
    wire rep_busy;

    // Stored shadow of the CAN settings awaiting a save and restart.
    reg [31:0] pend_tx_q;
    reg [31:0] pend_rx_q;
    reg [31:0] pend_rate_q;

    wire [7:0] sum_nxt = sum_q + rx_byte;
    // Parameter bytes sit at frame positions 3 to 6; the two-bit wrap maps them to word lanes 0 to 3.
    wire [1:0] par_idx = cnt_q[1:0] + 2'h1;
    wire last = (cnt_q == len_q - 8'h01);

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_q <= ST_HEAD;
            len_q <= 8'h00;
            cnt_q <= 8'h00;
            sum_q <= 8'h00;
            cmd_q <= 8'h00;
            par_q <= 32'h00000000;
            boot_q <= 1'b1;
            rep_start_q <= 1'b0;
            rep_code_q <= 8'h00;
            rep_status_q <= 8'h00;
            thresh_q <= `RCCH_RST_THRESH;
            thresh_en_q <= 1'b0;
            can_tx_ident_q <= `RCCH_RST_TX_IDENT;
            can_rx_ident_q <= `RCCH_RST_RX_IDENT;
            can_rate_q <= `RCCH_RST_CAN_RATE;
            pend_tx_q <= `RCCH_RST_TX_IDENT;
            pend_rx_q <= `RCCH_RST_RX_IDENT;
            pend_rate_q <= `RCCH_RST_CAN_RATE;
            nv_write_q <= 1'b0;
            nv_tx_ident_q <= 32'h00000000;
            nv_rx_ident_q <= 32'h00000000;
            nv_can_rate_q <= 32'h00000000;
            nv_thresh_q <= 16'h0000;
            busy_q <= 1'b0;
        end
        else
        begin
            rep_start_q <= 1'b0;
            nv_write_q <= 1'b0;
            if (boot_q)
            begin
                // Stored values take effect only at restart.
                boot_q <= 1'b0;
                thresh_q <= (boot_thresh == `RCCH_THRESH_FORBID) ? `RCCH_RST_THRESH : boot_thresh;
                thresh_en_q <= (boot_thresh != 16'h0000) && (boot_thresh != `RCCH_THRESH_FORBID);
                can_tx_ident_q <= boot_tx_ident;
                can_rx_ident_q <= boot_rx_ident;
                can_rate_q <= boot_can_rate;
                pend_tx_q <= boot_tx_ident;
                pend_rx_q <= boot_rx_ident;
                pend_rate_q <= boot_can_rate;
            end
            else
            begin
                case (st_q)
                    ST_HEAD:
                    begin
                        busy_q <= 1'b0;
                        if (rx_valid && rx_byte == `RCCH_HEAD_BYTE)
                        begin
                            st_q <= ST_LEN;
                            sum_q <= rx_byte;
                            cnt_q <= 8'h01;
                        end
                    end
                    ST_LEN:
                    begin
                        if (rx_valid)
                        begin
                            len_q <= rx_byte;
                            sum_q <= sum_nxt;
                            cnt_q <= 8'h02;
                            par_q <= 32'h00000000;
                            st_q <= (rx_byte < `RCCH_LEN_NOPARAM) ? ST_HEAD : ST_BODY;
                        end
                    end
                    ST_BODY:
                    begin
                        if (rx_valid)
                        begin
                            cnt_q <= cnt_q + 8'h01;
                            sum_q <= sum_nxt;
                            if (cnt_q == 8'h02)
                            begin
                                cmd_q <= rx_byte;
                                if (len_for(rx_byte) != len_q)
                                    st_q <= ST_HEAD;
                            end
                            else if (last)
                            begin
                                // Drop silently on checksum mismatch, or while a reply is still going.
                                if (rx_byte == sum_q && !rep_busy)
                                begin
                                    st_q <= ST_EXEC;
                                    busy_q <= 1'b1;
                                end
                                else
                                    st_q <= ST_HEAD;
                            end
                            else
                                par_q[8*par_idx +: 8] <= rx_byte;
                        end
                    end
                    ST_EXEC:
                    begin
                        st_q <= ST_HEAD;
                        rep_code_q <= cmd_q;
                        rep_status_q <= `RCCH_STATUS_OK;
                        case (cmd_q)
                            `RCCH_CMD_SAVE:
                            begin
                                nv_write_q <= 1'b1;
                                nv_thresh_q <= thresh_q;
                                nv_tx_ident_q <= pend_tx_q;
                                nv_rx_ident_q <= pend_rx_q;
                                nv_can_rate_q <= pend_rate_q;
                                st_q <= ST_SAVE;
                            end
                            `RCCH_CMD_THRESH:
                            begin
                                rep_start_q <= 1'b1;
                                if (par_q[15:0] == `RCCH_THRESH_FORBID)
                                    rep_status_q <= `RCCH_STATUS_FAIL;
                                else
                                begin
                                    thresh_q <= par_q[15:0];
                                    thresh_en_q <= (par_q[15:0] != 16'h0000);
                                end
                            end
                            `RCCH_CMD_TX_IDENT:
                            begin
                                rep_start_q <= 1'b1;
                                pend_tx_q <= par_q;
                            end
                            `RCCH_CMD_RX_IDENT:
                            begin
                                rep_start_q <= 1'b1;
                                pend_rx_q <= par_q;
                            end
                            `RCCH_CMD_CAN_RATE:
                            begin
                                rep_start_q <= 1'b1;
                                if (rate_ok(par_q))
                                    pend_rate_q <= par_q;
                                else
                                    rep_status_q <= `RCCH_STATUS_FAIL;
                            end
                            default:
                                rep_start_q <= 1'b0;
                        endcase
                    end
                    ST_SAVE:
                    begin
                        if (nv_done)
                        begin
                            rep_start_q <= 1'b1;
                            rep_status_q <= nv_fail ? `RCCH_STATUS_FAIL : `RCCH_STATUS_OK;
                            st_q <= ST_HEAD;
                        end
                    end
                    default:
                        st_q <= ST_HEAD;
                endcase
            end
        end
    end

    // ----------------------------------------
    // Reply serialiser
    // ----------------------------------------
    rcch_reply_tx u_reply (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .start(rep_start_q),
        .code(rep_code_q),
        .status(rep_status_q),
        .tx_valid_q(tx_valid),
        .tx_byte_q(tx_byte),
        .tx_ready(tx_ready),
        .busy_q(rep_busy)
    );

endmodule

// file: tb/rcch_top_sva.sv
// Assertion checker for the ports of the configuration command handler.
`timescale 1ns/1ps

module rcch_top_sva (
    // Clock and reset
    input wire clk_sys,
    input wire arst_n,
    // Observed ports
    input wire tx_valid,
    input wire [7:0] tx_byte,
    input wire tx_ready,
    input wire nv_write_q,
    input wire [15:0] nv_thresh_q,
    input wire [15:0] thresh_q,
    input wire thresh_en_q,
    input wire [31:0] can_tx_ident_q,
    input wire [31:0] can_rate_q
);
    // The live CAN values load from the boot inputs on the first edge, so they are frozen only after that.
    reg [1:0] up_q;
    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            up_q <= 2'h0;
        else if (up_q != 2'h2)
            up_q <= up_q + 2'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_tx_hold_stable: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
        else $error("reply byte changed while stalled");
    a_reply_head_first: assert property ($rose(tx_valid) |-> tx_byte == 8'h5a)
        else $error("reply did not open with the start byte");
    a_size_after_head: assert property (tx_valid && tx_ready && tx_byte == 8'h5a |=> tx_valid && tx_byte == 8'h05)
        else $error("reply size byte missing");
    a_code_after_size: assert property (tx_valid && tx_ready && tx_byte == 8'h05 |=> tx_valid &&
        (tx_byte == 8'h11 || tx_byte == 8'h4f || tx_byte == 8'h50 || tx_byte == 8'h51 || tx_byte == 8'h52))
        else $error("reply code not an instruction code");
    a_thresh_not_ffff: assert property (thresh_q != 16'hffff)
        else $error("forbidden threshold adopted");
    a_thresh_en_zero: assert property (thresh_en_q == (thresh_q != 16'h0000))
        else $error("threshold enable disagrees with value");
    a_save_live_thresh: assert property (nv_write_q |-> nv_thresh_q == thresh_q)
        else $error("stored threshold differs from live one");
    a_ident_frozen: assert property (up_q == 2'h2 |-> $stable(can_tx_ident_q))
        else $error("live send identifier changed");
    a_rate_frozen: assert property (up_q == 2'h2 |-> $stable(can_rate_q))
        else $error("live bit rate changed");
    c_reply: cover property ($rose(tx_valid));
    c_stall: cover property (tx_valid && !tx_ready);
    c_save: cover property (nv_write_q);
endmodule

bind rcch_top rcch_top_sva chk (.clk_sys(clk_sys), .arst_n(arst_n), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_ready(tx_ready), .nv_write_q(nv_write_q), .nv_thresh_q(nv_thresh_q), .thresh_q(thresh_q),
    .thresh_en_q(thresh_en_q), .can_tx_ident_q(can_tx_ident_q), .can_rate_q(can_rate_q));

// file: tb/rcch_host.sv
// Host controller model: sends framed instructions and collects reply bytes.
`timescale 1ns/1ps

module rcch_host (
    // Clock
    input wire clk_sys,
    // Instruction bytes to the handler
    output reg rx_valid,
    output reg [7:0] rx_byte,
    // Reply bytes from the handler
    input wire tx_valid,
    input wire [7:0] tx_byte,
    output reg tx_ready
);
    reg slow;
    reg [7:0] rep [0:7];
    integer rcnt;
    initial
    begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        tx_ready = 1'b0;
        slow = 1'b0;
        rcnt = 0;
    end
    // A slow host takes a byte only every other cycle, so each reply byte must be held.
    always @(posedge clk_sys)
    begin
        if (tx_valid && tx_ready && rcnt < 8)
        begin
            rep[rcnt] <= tx_byte;
            rcnt <= rcnt + 1;
        end
        tx_ready <= #1 slow ? ~tx_ready : 1'b1;
    end
    task put(input [7:0] b);
    begin
        @(posedge clk_sys);
        #1;
        rx_valid = 1'b1;
        rx_byte = b;
    end
    endtask
    // The bad mask flips checksum bits to make a corrupt frame on purpose.
    task send(input [7:0] code, input [31:0] val, input integer n, input [7:0] bad);
        reg [7:0] sum;
        integer i;
    begin
        rcnt = 0;
        sum = 8'h5a + n[7:0] + 8'h04 + code;
        put(8'h5a);
        put(n[7:0] + 8'h04);
        put(code);
        for (i = 0; i < n; i = i + 1)
        begin
            put(val[8*i +: 8]);
            sum = sum + val[8*i +: 8];
        end
        put(sum ^ bad);
        @(posedge clk_sys);
        #1;
        rx_valid = 1'b0;
        rx_byte = ~rx_byte;
    end
    endtask
endmodule

// file: tb/rcch_top_tb.sv
// Self-checking testbench for the configuration command handler.
`timescale 1ns/1ps
`include "rcch_consts.vh"

module rcch_top_tb;
    reg clk_sys;
    reg arst_n;
    reg nv_done;
    reg nv_fail;
    reg fail_mode;
    wire rx_valid, tx_valid, tx_ready, nv_write_q, thresh_en_q, busy_q;
    wire [7:0] rx_byte, tx_byte;
    wire [15:0] nv_thresh_q, thresh_q;
    wire [31:0] nv_tx_ident_q, nv_rx_ident_q, nv_can_rate_q, can_tx_ident_q, can_rx_ident_q, can_rate_q;
    reg [15:0] cap_th;
    reg [31:0] cap_tx, cap_rx, cap_rate;
    integer miscompares, num_checks, cycles;
    localparam [15:0] boot_th = 16'h0123;
    localparam [31:0] boot_tx = 32'h00000201;
    localparam [31:0] boot_rate = `RCCH_RATE_500K;

    rcch_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .nv_write_q(nv_write_q),
        .nv_tx_ident_q(nv_tx_ident_q), .nv_rx_ident_q(nv_rx_ident_q), .nv_can_rate_q(nv_can_rate_q),
        .nv_thresh_q(nv_thresh_q), .nv_done(nv_done), .nv_fail(nv_fail), .boot_thresh(boot_th),
        .boot_tx_ident(boot_tx), .boot_rx_ident(32'h00000202), .boot_can_rate(boot_rate),
        .thresh_q(thresh_q), .thresh_en_q(thresh_en_q), .can_tx_ident_q(can_tx_ident_q),
        .can_rx_ident_q(can_rx_ident_q), .can_rate_q(can_rate_q), .busy_q(busy_q));
    rcch_host host (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_ready(tx_ready));

    always #50 clk_sys = ~clk_sys;
    // The store answers three cycles after each write pulse.
    always @(posedge clk_sys)
    begin
        nv_done <= #1 1'b0;
        if (nv_write_q)
        begin
            cap_th = nv_thresh_q;
            cap_tx = nv_tx_ident_q;
            cap_rx = nv_rx_ident_q;
            cap_rate = nv_can_rate_q;
            repeat (3) @(posedge clk_sys);
            nv_done <= #1 1'b1;
            nv_fail <= #1 fail_mode;
        end
    end
    always @(posedge clk_sys)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            miscompares = miscompares + 1;
            end_of_test;
        end
    end
    task end_of_test;
    begin
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task chk(input [8*12:1] name, input [31:0] exp, input [31:0] got);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("[ERR] %0s expected %h seen %h", name, exp, got);
        end
    end
    endtask
    task reply(input [7:0] code, input [7:0] st);
        reg [7:0] s;
        integer i;
    begin
        s = 8'h5f + code + st;
        i = 0;
        while (host.rcnt < 5 && i < 300)
        begin
            @(posedge clk_sys);
            i = i + 1;
        end
        chk("reply count", 5, host.rcnt);
        chk("reply head", 8'h5a, host.rep[0]);
        chk("reply size", 8'h05, host.rep[1]);
        chk("reply code", code, host.rep[2]);
        chk("reply status", st, host.rep[3]);
        chk("reply sum", s, host.rep[4]);
        repeat (4) @(posedge clk_sys);
        chk("idle busy", 0, busy_q);
    end
    endtask
    task no_reply;
    begin
        repeat (60) @(posedge clk_sys);
        chk("no reply", 0, host.rcnt);
    end
    endtask
    task t_thresh;
    begin
        host.slow = 1'b1;
        host.send(`RCCH_CMD_THRESH, 32'h0000beef, 2, 8'h00);
        reply(`RCCH_CMD_THRESH, `RCCH_STATUS_OK);
        host.slow = 1'b0;
        chk("thresh", 16'hbeef, thresh_q);
        chk("thresh en", 1, thresh_en_q);
        host.send(`RCCH_CMD_THRESH, 32'h0000ffff, 2, 8'h00);
        reply(`RCCH_CMD_THRESH, `RCCH_STATUS_FAIL);
        chk("thresh kept", 16'hbeef, thresh_q);
        host.send(`RCCH_CMD_THRESH, 32'h00000000, 2, 8'h00);
        reply(`RCCH_CMD_THRESH, `RCCH_STATUS_OK);
        chk("thresh en", 0, thresh_en_q);
    end
    endtask
    task t_can;
        reg [31:0] rates [0:3];
        integer i;
    begin
        rates[0] = `RCCH_RATE_1M;
        rates[1] = `RCCH_RATE_500K;
        rates[2] = `RCCH_RATE_250K;
        rates[3] = `RCCH_RATE_125K;
        host.send(`RCCH_CMD_TX_IDENT, 32'h1a2b3c4d, 4, 8'h00);
        reply(`RCCH_CMD_TX_IDENT, `RCCH_STATUS_OK);
        host.send(`RCCH_CMD_RX_IDENT, 32'h55667788, 4, 8'h00);
        reply(`RCCH_CMD_RX_IDENT, `RCCH_STATUS_OK);
        for (i = 0; i < 4; i = i + 1)
        begin
            host.send(`RCCH_CMD_CAN_RATE, rates[i], 4, 8'h00);
            reply(`RCCH_CMD_CAN_RATE, `RCCH_STATUS_OK);
        end
        host.send(`RCCH_CMD_CAN_RATE, 32'h0007a121, 4, 8'h00);
        reply(`RCCH_CMD_CAN_RATE, `RCCH_STATUS_FAIL);
        chk("live tx id", boot_tx, can_tx_ident_q);
        chk("live rate", boot_rate, can_rate_q);
        chk("live rx id", 32'h00000202, can_rx_ident_q);
    end
    endtask
    task t_save;
    begin
        host.send(`RCCH_CMD_SAVE, 32'h00000000, 0, 8'h00);
        chk("save busy", 1, busy_q);
        reply(`RCCH_CMD_SAVE, `RCCH_STATUS_OK);
        chk("nv thresh", 16'h0000, cap_th);
        chk("nv tx id", 32'h1a2b3c4d, cap_tx);
        chk("nv rx id", 32'h55667788, cap_rx);
        chk("nv rate", `RCCH_RATE_125K, cap_rate);
        fail_mode = 1'b1;
        host.send(`RCCH_CMD_SAVE, 32'h00000000, 0, 8'h00);
        reply(`RCCH_CMD_SAVE, `RCCH_STATUS_FAIL);
        fail_mode = 1'b0;
    end
    endtask
    task t_bad;
    begin
        host.send(`RCCH_CMD_THRESH, 32'h00000777, 2, 8'h01);
        no_reply;
        host.send(`RCCH_CMD_THRESH, 32'h00000777, 4, 8'h00);
        no_reply;
        host.send(8'h01, 32'h00000000, 0, 8'h00);
        no_reply;
        chk("thresh", 16'h0000, thresh_q);
        host.put(8'h00);
        host.send(`RCCH_CMD_THRESH, 32'h00000777, 2, 8'h00);
        reply(`RCCH_CMD_THRESH, `RCCH_STATUS_OK);
        chk("thresh", 16'h0777, thresh_q);
    end
    endtask
    initial
    begin
        clk_sys = 1'b0;
        arst_n = 1'b0;
        nv_done = 1'b0;
        nv_fail = 1'b0;
        fail_mode = 1'b0;
        miscompares = 0;
        num_checks = 0;
        cycles = 0;
        repeat (12) @(posedge clk_sys);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("boot thresh", boot_th, thresh_q);
        chk("boot rate", boot_rate, can_rate_q);
        t_thresh;
        t_can;
        t_save;
        t_bad;
        end_of_test;
    end
endmodule
